// file: rtl/pse_pkg.sv
// Shared constants for the host register bank of the quad-port power controller.
// Assumes an 8-bit register space reached through the two-wire serial slave.
//==============================================================================
// Package
//==============================================================================
package pse_pkg;

  // Port count and event register count
  localparam int          NUM_PORTS       = 4;
  localparam int          NUM_EVENT_REGS  = 5;

  // Register offsets
  localparam logic [7:0]  ADDR_SUMMARY    = 8'h00;  // Interrupt summary, read only
  localparam logic [7:0]  ADDR_MASK       = 8'h01;  // Interrupt mask
  localparam logic [7:0]  ADDR_POWER_VIEW = 8'h02;  // Power event, plain view
  localparam logic [7:0]  ADDR_POWER_COR  = 8'h03;  // Power event, clear on read
  localparam logic [7:0]  ADDR_STATUS     = 8'h10;  // Power good / power on levels
  localparam logic [7:0]  ADDR_DEV_ADDR   = 8'h11;  // Latched address pins
  localparam logic [7:0]  ADDR_CONFIG     = 8'h17;  // Global configuration
  localparam logic [7:0]  ADDR_COMMAND    = 8'h1A;  // Command (clear all)
  localparam logic [7:0]  ADDR_PTR_LAST   = 8'h26;  // Pointer stops here

  // Event registers sit in view/clear-on-read pairs from the power register up
  localparam logic [7:0]  EVENT_STRIDE    = 8'h02;

  // Field positions
  localparam int          CFG_INT_EN_BIT  = 7;      // Global interrupt enable
  localparam int          CMD_CLEAR_BIT   = 7;      // Clear summary and events

  // Reset values
  localparam logic [7:0]  RESET_ZERO      = 8'h00;
  localparam logic [7:0]  MASK_AUTO_BITS  = 8'hE4;  // Bits 7,6,5,2 copy auto level

  // Serial addressing
  localparam logic [2:0]  SLAVE_ADDR_HI   = 3'h2;   // Upper three address bits 010
  localparam logic [6:0]  GLOBAL_ADDR     = 7'h30;  // Global write address (byte 0x60)

endpackage : pse_pkg

// file: rtl/pse_twi_slave.sv
// Two-wire serial slave byte engine: start/stop detection, address match, ACK.
// Assumes scl and sda_in arrive raw from pins; the register side is on clk.
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Serial slave
//==============================================================================
module pse_twi_slave (
  input  wire logic       clk,       // System clock
  input  wire logic       reset_n,   // Synchronous reset, active low
  input  wire logic       scl,       // Serial clock pin
  input  wire logic       sda_in,    // Serial data input pin
  input  wire logic [3:0] dev_addr,  // Latched low address bits
  output var  logic       cmd_stb,   // Command byte received
  output var  logic       data_stb,  // Data byte received
  output var  logic [7:0] wr_byte,   // Received byte
  output var  logic       rd_req,    // Next read byte wanted
  input  wire logic [7:0] rd_byte,   // Byte to send, valid a cycle after rd_req
  output var  logic       sda_oe     // Pull data output low
);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_ADDR_AK = 3'h3,
    ST_WRITE   = 3'h2,
    ST_WR_AK   = 3'h6,
    ST_READ    = 3'h7,
    ST_RD_AK   = 3'h5,
    ST_RD_WAIT = 3'h4
  } pse_twi_state_type;

  pse_twi_state_type state;          // Protocol state
  logic [2:0]        scl_sync;       // Two sync flops plus history
  logic [2:0]        sda_sync;       // Two sync flops plus history
  logic [7:0]        shift;          // Byte shifter
  logic [2:0]        bit_cnt;        // Bits done in current byte
  logic              ack_on;         // ACK pulse currently driven
  logic              is_read;        // Current transfer reads
  logic              first_byte;     // Next written byte is the command
  logic              start_seen;     // Start condition
  logic              stop_seen;      // Stop condition
  logic              scl_rise;       // Serial clock rising
  logic              scl_fall;       // Serial clock falling
  logic [7:0]        next_shift;     // Shifter with the sampled bit
  logic              addr_match;     // Own or global address

  // Synchronise pins; only the second flop and later are read
  always_ff @(posedge clk) begin
    scl_sync <= {scl_sync[1:0], scl};
    sda_sync <= {sda_sync[1:0], sda_in};
  end

  // Bus conditions from synchronised levels
  always_comb begin
    start_seen = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
    stop_seen  = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
    scl_rise   = scl_sync[1] && !scl_sync[2];
    scl_fall   = !scl_sync[1] && scl_sync[2];
    next_shift = {shift[6:0], sda_sync[1]};
    // Own address answers both directions, global only writes
    addr_match = (next_shift[7:1] == {pse_pkg::SLAVE_ADDR_HI, dev_addr}) ||
                 (next_shift[7:1] == pse_pkg::GLOBAL_ADDR && !next_shift[0]);
  end

  // Protocol sequencer
  always_ff @(posedge clk) begin
    cmd_stb  <= 1'b0;
    data_stb <= 1'b0;
    rd_req   <= 1'b0;
    if (!reset_n) begin
      state      <= ST_IDLE;
      shift      <= 8'h00;
      bit_cnt    <= 3'h0;
      ack_on     <= 1'b0;
      is_read    <= 1'b0;
      first_byte <= 1'b0;
      sda_oe     <= 1'b0;
      wr_byte    <= 8'h00;
    end else if (start_seen) begin
      // Start or repeated start restarts addressing
      state   <= ST_ADDR;
      bit_cnt <= 3'h0;
      sda_oe  <= 1'b0;
      ack_on  <= 1'b0;
    end else if (stop_seen) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR: if (scl_rise) begin
          shift   <= next_shift;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            is_read    <= next_shift[0];
            first_byte <= 1'b1;
            state      <= addr_match ? ST_ADDR_AK : ST_IDLE;
          end
        end
        ST_ADDR_AK: if (scl_fall) begin
          if (!ack_on) begin
            sda_oe <= 1'b1;
            ack_on <= 1'b1;
            rd_req <= is_read;
          end else begin
            ack_on  <= 1'b0;
            bit_cnt <= 3'h0;
            if (is_read) begin
              shift  <= rd_byte;
              sda_oe <= !rd_byte[7];
              state  <= ST_READ;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_WRITE;
            end
          end
        end
        ST_WRITE: if (scl_rise) begin
          shift   <= next_shift;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            wr_byte    <= next_shift;
            cmd_stb    <= first_byte;
            data_stb   <= !first_byte;
            first_byte <= 1'b0;
            state      <= ST_WR_AK;
          end
        end
        ST_WR_AK: if (scl_fall) begin
          sda_oe  <= !ack_on;
          ack_on  <= !ack_on;
          bit_cnt <= 3'h0;
          if (ack_on) begin
            state <= ST_WRITE;
          end
        end
        ST_READ: if (scl_fall) begin
          bit_cnt <= bit_cnt + 3'h1;
          shift   <= {shift[6:0], 1'b0};
          if (bit_cnt == 3'h7) begin
            sda_oe <= 1'b0;                           // Release for master ACK
            state  <= ST_RD_AK;
          end else begin
            sda_oe <= !shift[6];
          end
        end
        ST_RD_AK: if (scl_rise) begin
          // ACK asks for one more byte, NACK ends the read
          rd_req <= !sda_sync[1];
          state  <= sda_sync[1] ? ST_IDLE : ST_RD_WAIT;
        end
        ST_RD_WAIT: if (scl_fall) begin
          shift   <= rd_byte;
          sda_oe  <= !rd_byte[7];
          bit_cnt <= 3'h0;
          state   <= ST_READ;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : pse_twi_slave
`default_nettype wire

// file: rtl/pse_host_regs.sv
// Host register bank and interrupt aggregation for the quad-port controller.
// Assumes event inputs are one-cycle pulses and status levels on clk; pins raw.
//
// Functional notes
// - Write frame: address, then command byte.
// - Stop after command only sets pointer.
// - Data bytes store at pointer, pointer advances.
// - Reads return pointer register, pointer advances.
// - Pointer increments up to 0x26, then holds.
// - Writes to unimplemented addresses are blocked.
// - Summary register drives low interrupt output.
// - Command bit 7 clears summary and events.
// - Reset clears summary register.
// - Global enable bit gates interrupt output.
// - Mask bit n enables summary bit n.
// - Mask reset copies auto level into bits.
// - Summary bits 7,6,5,2 OR their events.
// - Summary bits 4,3,1,0 OR their events.
// - Power edge flags set on any edge.
// - Power events readable plain or clear-on-read.
// - Power events: good flags high, enable low.
// - Reset clears power event register.
// - Detect and class completion set flags.
// - Own address is 010 plus latched pins.
// - Global address 0x60 accepts writes.
`timescale 1ns/1ps
`default_nettype none
//==============================================================================
// Top
//==============================================================================
module pse_host_regs #(
  parameter int NUM_PORTS = pse_pkg::NUM_PORTS            // Ports served
) (
  input  wire logic                 clk,                   // 40 MHz clock
  input  wire logic                 reset_n,               // Synchronous reset, low
  input  wire logic                 scl,                   // Serial clock pin
  input  wire logic                 sda_in,                // Serial data input pin
  output var  logic                 sda_out,               // Serial data out level
  output var  logic                 sda_oe,                // Serial data pull enable
  input  wire logic [3:0]           addr_pins,             // Address strap pins
  input  wire logic                 auto_mode,             // Auto mode strap pin
  output var  logic                 int_n,                 // Interrupt, active low
  input  wire logic [NUM_PORTS-1:0] port_power_good,       // Power good levels
  input  wire logic [NUM_PORTS-1:0] port_power_on,         // Power enable levels
  input  wire logic [NUM_PORTS-1:0] port_detect_done,      // Detection finished
  input  wire logic [NUM_PORTS-1:0] port_class_done,       // Classification finished
  input  wire logic [NUM_PORTS-1:0] load_removed_evt,      // Load disconnect
  input  wire logic [NUM_PORTS-1:0] overcurrent_evt,       // Overcurrent shutdown
  input  wire logic [NUM_PORTS-1:0] class_overcurrent_evt, // Class current exceeded
  input  wire logic [NUM_PORTS-1:0] startup_fail_evt,      // Startup failed
  input  wire logic [7:0]           supply_evt             // Supply events
);

  localparam int NEV = pse_pkg::NUM_EVENT_REGS;

  //============================================================================
  // Declarations
  //============================================================================
  logic [1:0]       auto_sync;        // Auto strap synchroniser
  logic [3:0]       addr_sync1;       // Address strap first stage
  logic [3:0]       addr_sync2;       // Address strap second stage
  logic [3:0]       dev_addr;         // Address latched at reset release
  logic             cmd_stb;          // Command byte arrived
  logic             data_stb;         // Data byte arrived
  logic [7:0]       wr_byte;          // Received byte
  logic             rd_req;           // Read byte wanted
  logic [7:0]       rd_byte;          // Byte handed to the slave
  logic             slave_oe;         // Slave pull request
  logic [7:0]       ptr;              // Address pointer
  logic [7:0]       next_ptr;         // Pointer after one access
  logic [7:0]       mask;             // Interrupt mask
  logic [7:0]       config_reg;       // Global configuration
  logic             clear_all;        // Clear-all command pulse
  logic [NUM_PORTS-1:0] pg_prev;      // Last power good level
  logic [NUM_PORTS-1:0] pen_prev;     // Last power enable level
  logic [7:0]       ev_set [NEV];     // Per event register set pulses
  logic [7:0]       ev_reg [NEV];     // Event registers
  logic [7:0]       summary;          // Interrupt summary
  logic [7:0]       next_summary;     // Summary from events
  logic [7:0]       read_value;       // Register at pointer

  //============================================================================
  // Straps
  //============================================================================
  // Two-flop synchronisers for the strap pins, running through reset
  always_ff @(posedge clk) begin
    auto_sync  <= {auto_sync[0], auto_mode};
    addr_sync1 <= addr_pins;
    addr_sync2 <= addr_sync1;
  end

  // Address follows the pins during reset and freezes at release
  // Later strap changes are ignored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dev_addr <= addr_sync2;
    end
  end

  //============================================================================
  // Serial slave
  //============================================================================
  pse_twi_slave u_slave (
    .clk      (clk),
    .reset_n  (reset_n),
    .scl      (scl),
    .sda_in   (sda_in),
    .dev_addr (dev_addr),
    .cmd_stb  (cmd_stb),
    .data_stb (data_stb),
    .wr_byte  (wr_byte),
    .rd_req   (rd_req),
    .rd_byte  (rd_byte),
    .sda_oe   (slave_oe)
  );

  // Open-drain data output: level always low, enable re-registered
  // Line is only ever pulled, never driven high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= slave_oe;
    end
  end

  //============================================================================
  // Pointer
  //============================================================================
  // Advance until the last address, then hold; never wraps
  // A pointer set past the end stays put
  always_comb begin
    if (ptr < pse_pkg::ADDR_PTR_LAST) begin
      next_ptr = ptr + 8'h01;
    end else begin
      next_ptr = ptr;
    end
  end

  // Command byte loads the pointer; each data byte moves it on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr <= pse_pkg::RESET_ZERO;
    end else if (cmd_stb) begin
      ptr <= wr_byte;
    end else if (data_stb || rd_req) begin
      ptr <= next_ptr;
    end
  end

  //============================================================================
  // Writable registers
  //============================================================================
  // Mask register; reset copies the sampled auto level into its marked bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask <= auto_sync[1] ? pse_pkg::MASK_AUTO_BITS : pse_pkg::RESET_ZERO;
    end else if (data_stb && ptr == pse_pkg::ADDR_MASK) begin
      mask <= wr_byte;
    end
  end

  // Configuration register holding the global interrupt enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      config_reg <= pse_pkg::RESET_ZERO;
    end else if (data_stb && ptr == pse_pkg::ADDR_CONFIG) begin
      config_reg <= wr_byte;
    end
  end

  // Command register acts only; a write to it stores nothing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clear_all <= 1'b0;
    end else begin
      clear_all <= data_stb && ptr == pse_pkg::ADDR_COMMAND &&
                   wr_byte[pse_pkg::CMD_CLEAR_BIT];
    end
  end

  //============================================================================
  // Event sources
  //============================================================================
  // Previous levels for edge detection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pg_prev  <= '0;
      pen_prev <= '0;
    end else begin
      pg_prev  <= port_power_good;
      pen_prev <= port_power_on;
    end
  end

  // Set pulses per register: power, detect, fault, startup, supply
  // Level inputs give edges; others pulse
  always_comb begin
    ev_set[0] = {port_power_good ^ pg_prev, port_power_on ^ pen_prev};
    ev_set[1] = {port_class_done, port_detect_done};
    ev_set[2] = {load_removed_evt, overcurrent_evt};
    ev_set[3] = {class_overcurrent_evt, startup_fail_evt};
    ev_set[4] = supply_evt;
  end

  //============================================================================
  // Event registers
  //============================================================================
  // Sticky flags, viewed at an even address and cleared by a read at the odd
  // one; a new event in the clearing cycle survives the clear
  for (genvar k = 0; k < NEV; k++) begin : g_event
    localparam logic [7:0] COR_ADDR = pse_pkg::ADDR_POWER_COR +
                                      8'(k * int'(pse_pkg::EVENT_STRIDE));
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        ev_reg[k] <= pse_pkg::RESET_ZERO;
      end else if (clear_all || (rd_req && ptr == COR_ADDR)) begin
        ev_reg[k] <= ev_set[k];
      end else begin
        ev_reg[k] <= ev_reg[k] | ev_set[k];
      end
    end
  end

  //============================================================================
  // Summary and interrupt
  //============================================================================
  // Each summary bit gathers one group of event flags
  always_comb begin
    next_summary[7] = |ev_reg[4];
    next_summary[6] = |ev_reg[3];
    next_summary[5] = |ev_reg[2][3:0];
    next_summary[4] = |ev_reg[1][7:4];
    next_summary[3] = |ev_reg[1][3:0];
    next_summary[2] = |ev_reg[2][7:4];
    next_summary[1] = |ev_reg[0][7:4];
    next_summary[0] = |ev_reg[0][3:0];
  end

  // Summary follows the events; the clear-all pulse also empties it
  // One clock behind the flags
  always_ff @(posedge clk) begin
    if (!reset_n || clear_all) begin
      summary <= pse_pkg::RESET_ZERO;
    end else begin
      summary <= next_summary;
    end
  end

  // Interrupt low only with global enable and a masked-in pending bit
  // Registered so the pin never glitches
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !(config_reg[pse_pkg::CFG_INT_EN_BIT] &&
                 |(summary & mask));
    end
  end

  //============================================================================
  // Read path
  //============================================================================
  // Register at the pointer; unimplemented addresses read zero
  always_comb begin
    read_value = pse_pkg::RESET_ZERO;
    case (ptr)
      pse_pkg::ADDR_SUMMARY:  read_value = summary;
      pse_pkg::ADDR_MASK:     read_value = mask;
      pse_pkg::ADDR_STATUS:   read_value = {port_power_good, port_power_on};
      pse_pkg::ADDR_DEV_ADDR: read_value = {4'h0, dev_addr};
      pse_pkg::ADDR_CONFIG:   read_value = config_reg;
      default: begin
        // Both addresses of each event pair show the same flags
        for (int k = 0; k < NEV; k++) begin
          if (ptr[7:1] == 7'((int'(pse_pkg::ADDR_POWER_VIEW) + 2 * k) >> 1)) begin
            read_value = ev_reg[k];
          end
        end
      end
    endcase
  end

  // Byte captured when the slave asks, before the pointer moves
  // Read value is held for the whole byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_byte <= pse_pkg::RESET_ZERO;
    end else if (rd_req) begin
      rd_byte <= read_value;
    end
  end

endmodule : pse_host_regs
`default_nettype wire

// file: testbench/pse_host_regs_chk.sv
// Port checker for the host register bank.
// Assumes it is bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
//====
// Checker
//====
module pse_host_regs_chk #(
  parameter int NUM_PORTS = 4                        // Ports served
) (
  input wire logic                 clk,                   // Clock
  input wire logic                 reset_n,               // Reset, low
  input wire logic                 scl,                   // Serial clock
  input wire logic                 sda_in,                // Data line
  input wire logic                 sda_out,               // Data level
  input wire logic                 sda_oe,                // Data pull
  input wire logic                 int_n,                 // Interrupt
  input wire logic [NUM_PORTS-1:0] port_power_good,       // Levels
  input wire logic [NUM_PORTS-1:0] port_power_on,         // Levels
  input wire logic [NUM_PORTS-1:0] port_detect_done,      // Pulses
  input wire logic [NUM_PORTS-1:0] port_class_done,       // Pulses
  input wire logic [NUM_PORTS-1:0] load_removed_evt,      // Pulses
  input wire logic [NUM_PORTS-1:0] overcurrent_evt,       // Pulses
  input wire logic [NUM_PORTS-1:0] class_overcurrent_evt, // Pulses
  input wire logic [NUM_PORTS-1:0] startup_fail_evt,      // Pulses
  input wire logic [7:0]           supply_evt             // Pulses
);
  logic [3:0] idle_cnt;  // Cycles of idle bus
  logic [3:0] quiet_cnt; // Cycles with no cause for int_n change
  logic       seen;      // Serial clock has moved since reset
  wire logic  ev = |{port_detect_done, port_class_done, load_removed_evt, overcurrent_evt,
                     class_overcurrent_evt, startup_fail_evt, supply_evt};
  // Saturating span counters
  always_ff @(posedge clk) begin
    idle_cnt <= (!reset_n || !(scl && sda_in)) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'h8};
    quiet_cnt <= (!reset_n || ev || !$stable(port_power_good) || !$stable(port_power_on)
                  || idle_cnt != 4'h8) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'h8};
  end
  // Traffic seen flag
  always_ff @(posedge clk) begin
    seen <= reset_n && (seen || !scl);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence oe_drop;
    ##[1:100] !sda_oe;
  endsequence
  reset_idle_a: assert property ($rose(reset_n) |-> int_n && !sda_oe)
    else $error("Outputs active after reset");
  out_zero_a: assert property (sda_out == 1'h0)
    else $error("Data level not low");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !$past(scl, 3))
    else $error("Data pull moved in clock high");
  oe_release_a: assert property ($rose(sda_oe) |-> oe_drop)
    else $error("Data pull held too long");
  bus_idle_a: assert property (idle_cnt == 4'h8 |-> !sda_oe)
    else $error("Data pull on idle bus");
  int_off_a: assert property (!seen |-> int_n)
    else $error("Interrupt before enable");
  int_quiet_a: assert property (quiet_cnt == 4'h8 |-> $stable(int_n))
    else $error("Interrupt moved without cause");
  int_clear_a: assert property ($rose(int_n) |-> idle_cnt != 4'h8)
    else $error("Interrupt released without access");
endmodule : pse_host_regs_chk
bind pse_host_regs pse_host_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk, .reset_n, .scl,
  .sda_in, .sda_out, .sda_oe, .int_n, .port_power_good, .port_power_on, .port_detect_done,
  .port_class_done, .load_removed_evt, .overcurrent_evt, .class_overcurrent_evt,
  .startup_fail_evt, .supply_evt);
`default_nettype wire

// file: testbench/pse_twi_master.sv
// Two-wire serial master model with a 200 ns bit.
// Assumes a pull-up on data; the device only pulls it low.
`timescale 1ns/1ps
`default_nettype none
//====
// Master
//====
module pse_twi_master (
  input  wire logic clk,    // Paces the link
  input  wire logic sda_oe, // Device pulls data low
  output var  logic scl,    // Clock, idles high
  output var  logic sda_in  // Data line as wired
);
  logic drv = 1'h1; // Master drive, high is released
  initial scl = 1'h1;
  // Wired-and with pull-up
  assign sda_in = drv & ~sda_oe;
  // Quarter bit
  task automatic qtr();
    repeat (2) @(negedge clk);
  endtask : qtr
  // One bit, line sampled mid high
  task automatic bit_x(input logic b, output logic r);
    drv = b;
    qtr();
    scl = 1'h1;
    qtr();
    r = sda_in;
    qtr();
    scl = 1'h0;
    qtr();
  endtask : bit_x
  // Start, or repeated start to keep the pointer ours
  task automatic start();
    drv = 1'h1;
    qtr();
    scl = 1'h1;
    qtr();
    drv = 1'h0;
    qtr();
    scl = 1'h0;
    qtr();
  endtask : start
  // Stop, bus left idle
  task automatic stop();
    drv = 1'h0;
    qtr();
    scl = 1'h1;
    qtr();
    drv = 1'h1;
    qtr();
  endtask : stop
  // Byte out, MSB first, returns acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, r);
    ack = !r;
  endtask : send
  // Byte in, then acknowledge if more wanted
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
    bit_x(!more, r);
  endtask : recv
endmodule : pse_twi_master
`default_nettype wire

// file: testbench/pse_host_regs_bench.sv
// Self-checking bench for the host register bank.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
//====
// Bench
//====
module pse_host_regs_bench;
  localparam logic [7:0] DEV_W = 8'h4A; // Own address, write
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic scl, sda_in, sda_out, sda_oe, int_n;
  logic [3:0] pg = '0, pon = '0, det = '0, cls = '0, oc = '0, zero4 = '0;
  logic [7:0] sup = '0;
  logic [7:0] q8 [$]; // Bytes to send or expect
  int num_errors = 0;
  int cmp_count = 0;
  pse_host_regs uut (.clk, .reset_n, .scl, .sda_in, .sda_out, .sda_oe, .addr_pins(4'h5),
    .auto_mode(1'h1), .int_n, .port_power_good(pg), .port_power_on(pon),
    .port_detect_done(det), .port_class_done(cls), .load_removed_evt(zero4),
    .overcurrent_evt(oc), .class_overcurrent_evt(zero4), .startup_fail_evt(zero4),
    .supply_evt(sup));
  pse_twi_master m (.clk, .sda_oe, .scl, .sda_in);
  initial forever #12.5 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h0, got}, {7'h0, exp});
  endtask : cmp1
  // Address, pointer, queued data, stop
  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic ok);
    logic k;
    m.start();
    m.send(a, k);
    cmp1(k, ok);
    m.send(p, k);
    foreach (q8[i]) m.send(q8[i], k);
    m.stop();
    q8 = {};
  endtask : wr
  // Optional pointer set, then read and compare queued bytes
  task automatic rd(input logic [7:0] p, input logic set);
    logic k;
    logic [7:0] v;
    m.start();
    if (set) begin
      m.send(DEV_W, k);
      m.send(p, k);
      m.start();
    end
    m.send(DEV_W | 8'h01, k);
    foreach (q8[i]) begin
      m.recv(i < q8.size() - 1, v);
      cmp8(v, q8[i]);
    end
    m.stop();
    q8 = {};
  endtask : rd
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #1_000_000;
    num_errors++;
    give_verdict();
  end
  initial begin
    tick(8);
    reset_n = 1'h1;
    tick(2);
    q8 = {8'h00, 8'hE4, 8'h00, 8'h00};
    rd(8'h00, 1'h1);
    q8 = {8'hFF};
    wr(8'h4C, 8'h01, 1'h0);
    q8 = {8'h00, 8'h80};
    wr(8'h60, 8'h16, 1'h1);
    wr(DEV_W, 8'h01, 1'h1);
    q8 = {8'hE4, 8'h00};
    rd(8'h00, 1'h0);
    q8 = {8'h00, 8'h80};
    rd(8'h16, 1'h1);
    q8 = {8'hFF};
    wr(DEV_W, 8'h01, 1'h1);
    {pg, pon, det, cls, oc} = {4'h2, 4'h8, 4'h1, 4'h4, 4'h1};
    tick(1);
    {det, cls, oc} = '0;
    tick(6);
    cmp1(int_n, 1'h0);
    q8 = {8'h3B, 8'hFF, 8'h28, 8'h28, 8'h41, 8'h41, 8'h01, 8'h01};
    rd(8'h00, 1'h1);
    q8 = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(8'h02, 1'h1);
    cmp1(int_n, 1'h1);
    q8 = {8'h00};
    wr(DEV_W, 8'h17, 1'h1);
    sup = 8'h01;
    tick(1);
    sup = 8'h00;
    tick(6);
    cmp1(int_n, 1'h1);
    q8 = {8'h7F};
    wr(DEV_W, 8'h01, 1'h1);
    q8 = {8'h80};
    wr(DEV_W, 8'h17, 1'h1);
    tick(6);
    cmp1(int_n, 1'h1);
    q8 = {8'h80};
    wr(DEV_W, 8'h01, 1'h1);
    tick(6);
    cmp1(int_n, 1'h0);
    q8 = {8'h00, 8'h00, 8'h00};
    rd(8'h25, 1'h1);
    q8 = {8'h80};
    wr(DEV_W, 8'h1A, 1'h1);
    q8 = {8'h00, 8'h80, 8'h00};
    rd(8'h00, 1'h1);
    cmp1(int_n, 1'h1);
    give_verdict();
  end
endmodule : pse_host_regs_bench
`default_nettype wire
